//--- verilog/deser_config_register_bank.sv
/*
 * Configuration register bank of the deserializer with its two-wire
 * serial control bus slave (7-bit address, pointer byte, auto-increment).
 * Assumes SCL and SDA are slow against the 25 MHz clock (at least four
 * clocks per SCL level) and that SDA is an open-drain wire resolved outside.
 */
`timescale 1ns/1ns
module deser_config_register_bank (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Serial control bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Strap and control pins
	input wire deser_cfg_pkg::strap_pins_t strap_pins_in,
	// Configuration to the deserializer core
	output deser_cfg_pkg::core_cfg_t core_cfg_out
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic scl_meta;
		logic scl_sync;
		logic scl_prev;
		logic sda_meta;
		logic sda_sync;
		logic sda_prev;
		deser_cfg_pkg::strap_pins_t pins_meta;
		deser_cfg_pkg::strap_pins_t pins_sync;
		deser_cfg_pkg::bus_state_t bus;
		deser_cfg_pkg::byte_kind_t kind;
		logic [2:0] bit_count;
		logic [7:0] shift;
		logic [7:0] pointer;
		logic read_mode;
		logic master_acked;
		logic sda_drive_low;
		deser_cfg_pkg::main_cfg_t main;
		deser_cfg_pkg::bus_addr_t addr;
		deser_cfg_pkg::out_feat_t feat;
		deser_cfg_pkg::core_cfg_t cfg;
	} bank_state_t;

	bank_state_t s;
	bank_state_t next_s;

	// Read decode, shared by first byte of a read and every following byte
	function automatic logic [7:0] read_reg(input logic [7:0] ptr,
		input deser_cfg_pkg::main_cfg_t m, input deser_cfg_pkg::bus_addr_t a,
		input deser_cfg_pkg::out_feat_t f);
		case (ptr)
			deser_cfg_pkg::REG_MAIN_CONFIG: read_reg = m;
			deser_cfg_pkg::REG_BUS_ADDR: read_reg = a;
			deser_cfg_pkg::REG_OUT_FEATURES: read_reg = f;
			default: read_reg = deser_cfg_pkg::UNMAPPED_READ_VALUE;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [7:0] rx_byte;
	logic [7:0] rd_byte;
	logic src_regs;

	// Edges use the second and third stages only, never the first
	assign scl_rise = s.scl_sync & ~s.scl_prev;
	assign scl_fall = ~s.scl_sync & s.scl_prev;
	assign bus_start = s.scl_sync & s.scl_prev & s.sda_prev & ~s.sda_sync;
	assign bus_stop = s.scl_sync & s.scl_prev & ~s.sda_prev & s.sda_sync;
	assign rx_byte = {s.shift[6:0], s.sda_sync};
	assign rd_byte = read_reg(s.pointer, s.main, s.addr, s.feat);
	assign src_regs = s.main.config_source_select;

	// Bus slave and register writes
	always_comb begin
		next_s = s;
		next_s.scl_meta = scl_in;
		next_s.scl_sync = s.scl_meta;
		next_s.scl_prev = s.scl_sync;
		next_s.sda_meta = sda_in;
		next_s.sda_sync = s.sda_meta;
		next_s.sda_prev = s.sda_sync;
		next_s.pins_meta = strap_pins_in;
		next_s.pins_sync = s.pins_meta;
		if (bus_start) begin
			// A repeated start restarts address matching in any state
			next_s.bus = deser_cfg_pkg::BUS_RX;
			next_s.kind = deser_cfg_pkg::KIND_ADDR;
			next_s.bit_count = 3'h0;
			next_s.sda_drive_low = 1'b0;
		end else if (bus_stop) begin
			next_s.bus = deser_cfg_pkg::BUS_IDLE;
			next_s.sda_drive_low = 1'b0;
		end else begin
			case (s.bus)
				deser_cfg_pkg::BUS_RX: begin
					if (scl_rise) begin
						next_s.shift = rx_byte;
						next_s.bit_count = s.bit_count + 3'h1;
						if (s.bit_count == deser_cfg_pkg::BIT_COUNT_LAST) begin
							next_s.bus = deser_cfg_pkg::BUS_ACK;
							case (s.kind)
								deser_cfg_pkg::KIND_ADDR: begin
									// Foreign address: drop off the bus until next start
									if (rx_byte[7:1] == s.cfg.active_address) begin
										next_s.read_mode = rx_byte[0];
									end else begin
										next_s.bus = deser_cfg_pkg::BUS_IDLE;
									end
								end
								deser_cfg_pkg::KIND_PTR: begin
									next_s.pointer = rx_byte;
								end
								default: begin
									// Unmapped pointers are acked but not stored
									case (s.pointer)
										deser_cfg_pkg::REG_MAIN_CONFIG: begin
											next_s.main = deser_cfg_pkg::main_cfg_t'(rx_byte);
										end
										deser_cfg_pkg::REG_BUS_ADDR: begin
											next_s.addr = deser_cfg_pkg::bus_addr_t'(rx_byte);
										end
										deser_cfg_pkg::REG_OUT_FEATURES: begin
											next_s.feat = deser_cfg_pkg::out_feat_t'(rx_byte);
										end
										default: begin
										end
									endcase
									next_s.pointer = s.pointer + 8'h01;
								end
							endcase
						end
					end
				end
				deser_cfg_pkg::BUS_ACK: begin
					if (scl_fall) begin
						if (!s.sda_drive_low) begin
							next_s.sda_drive_low = 1'b1;
						end else if (s.kind == deser_cfg_pkg::KIND_ADDR && s.read_mode) begin
							next_s.bus = deser_cfg_pkg::BUS_TX;
							next_s.shift = rd_byte;
							next_s.sda_drive_low = ~rd_byte[7];
							next_s.bit_count = 3'h0;
						end else begin
							next_s.bus = deser_cfg_pkg::BUS_RX;
							next_s.kind = (s.kind == deser_cfg_pkg::KIND_ADDR) ?
								deser_cfg_pkg::KIND_PTR : deser_cfg_pkg::KIND_DATA;
							next_s.bit_count = 3'h0;
							next_s.sda_drive_low = 1'b0;
						end
					end
				end
				deser_cfg_pkg::BUS_TX: begin
					if (scl_rise) begin
						next_s.bit_count = s.bit_count + 3'h1;
					end else if (scl_fall) begin
						if (s.bit_count == 3'h0) begin
							next_s.sda_drive_low = 1'b0;
							next_s.bus = deser_cfg_pkg::BUS_MACK;
							next_s.master_acked = 1'b0;
							next_s.pointer = s.pointer + 8'h01;
						end else begin
							next_s.shift = {s.shift[6:0], 1'b0};
							next_s.sda_drive_low = ~s.shift[6];
						end
					end
				end
				deser_cfg_pkg::BUS_MACK: begin
					// Master nack ends the read; wait for stop or start
					if (scl_rise) begin
						if (s.sda_sync) begin
							next_s.bus = deser_cfg_pkg::BUS_IDLE;
						end else begin
							next_s.master_acked = 1'b1;
						end
					end else if (scl_fall && s.master_acked) begin
						next_s.bus = deser_cfg_pkg::BUS_TX;
						next_s.shift = rd_byte;
						next_s.sda_drive_low = ~rd_byte[7];
						next_s.bit_count = 3'h0;
					end
				end
				default: begin
				end
			endcase
		end

		// Effective configuration: pins or registers, one clock behind
		next_s.cfg.low_freq_spread_range = src_regs ? s.main.low_freq_spread_range :
			s.pins_sync.low_freq_range;
		next_s.cfg.lane_bit_order_select = src_regs ? s.main.lane_bit_order_select :
			s.pins_sync.lane_bit_order;
		next_s.cfg.compat_mode = src_regs ? s.main.compat_mode_field :
			s.pins_sync.compat_mode;
		next_s.cfg.output_enable_bit = src_regs ? s.feat.output_enable_bit :
			s.pins_sync.output_enable;
		next_s.cfg.output_idle_state_select = src_regs ? s.feat.output_idle_state_select :
			s.pins_sync.output_idle_state;
		next_s.cfg.swing_select = src_regs ? s.feat.swing_select :
			s.pins_sync.swing;
		// Sleep and oscillator have no pins, so the register always rules
		next_s.cfg.sleep = s.main.sleep;
		next_s.cfg.fallback_oscillator_select = s.feat.fallback_oscillator_select;
		// The bus address ignores the config source and has its own select
		next_s.cfg.active_address = s.addr.bus_address_source ?
			s.addr.bus_address_field : s.pins_sync.pin_address;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Sleep is a plain bit here, so the bank keeps its contents through it
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			s <= '0;
			s.scl_meta <= 1'b1;
			s.scl_sync <= 1'b1;
			s.scl_prev <= 1'b1;
			s.sda_meta <= 1'b1;
			s.sda_sync <= 1'b1;
			s.sda_prev <= 1'b1;
			s.main <= deser_cfg_pkg::main_cfg_t'(deser_cfg_pkg::MAIN_CONFIG_RESET);
			s.addr <= deser_cfg_pkg::bus_addr_t'(deser_cfg_pkg::BUS_ADDR_RESET);
			s.feat <= deser_cfg_pkg::out_feat_t'(deser_cfg_pkg::OUT_FEATURES_RESET);
		end else begin
			s <= next_s;
		end
	end

	// Open-drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe_out = s.sda_drive_low;
	assign core_cfg_out = s.cfg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_range;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		src_regs |=> s.cfg.low_freq_spread_range == $past(s.main.low_freq_spread_range);
	endproperty
	a_range: assert property (p_range) else $error("spread range not from register");

	property p_lane;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		src_regs && s.main.lane_bit_order_select |=> s.cfg.lane_bit_order_select;
	endproperty
	a_lane: assert property (p_lane) else $error("lane order not from register");

	property p_filter;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		src_regs && s.main.compat_mode_field == deser_cfg_pkg::MODE_NORMAL_FILTER
		|=> s.cfg.compat_mode == deser_cfg_pkg::MODE_NORMAL_FILTER;
	endproperty
	a_filter: assert property (p_filter) else $error("filter mode not applied");

	property p_legacy;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		src_regs && s.main.compat_mode_field == deser_cfg_pkg::MODE_LEGACY_GEN2
		|=> s.cfg.compat_mode == deser_cfg_pkg::MODE_LEGACY_GEN2;
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy mode not applied");

	property p_sleep;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(s.main.sleep) |=> s.cfg.sleep && $stable(s.feat) && $stable(s.addr);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not held or bank lost");

	property p_pins;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		!src_regs |=> s.cfg.compat_mode == $past(s.pins_sync.compat_mode)
			&& s.cfg.swing_select == $past(s.pins_sync.swing);
	endproperty
	a_pins: assert property (p_pins) else $error("pins ignored in pin mode");

	property p_regs_oe;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		src_regs |=> s.cfg.output_enable_bit == $past(s.feat.output_enable_bit);
	endproperty
	a_regs_oe: assert property (p_regs_oe) else $error("output enable not from register");

	property p_addr;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		s.addr.bus_address_source |=> s.cfg.active_address == $past(s.addr.bus_address_field);
	endproperty
	a_addr: assert property (p_addr) else $error("bus address not from register");

	property p_reset;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(rst_n_in) |-> s.addr == deser_cfg_pkg::BUS_ADDR_RESET
			&& s.main == deser_cfg_pkg::MAIN_CONFIG_RESET
			&& s.feat == deser_cfg_pkg::OUT_FEATURES_RESET;
	endproperty
	a_reset: assert property (p_reset) else $error("wrong reset value");

	property p_swing;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		src_regs && !s.feat.swing_select |=> !s.cfg.swing_select;
	endproperty
	a_swing: assert property (p_swing) else $error("swing not from register");

	property p_ack;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		s.bus == deser_cfg_pkg::BUS_ACK && scl_fall && !s.sda_drive_low && !bus_start
		&& !bus_stop |=> sda_oe_out;
	endproperty
	a_ack: assert property (p_ack) else $error("acknowledge not driven");

endmodule // deser_config_register_bank

//--- inc/deser_cfg_pkg.sv
/*
 * Constants, register layouts and state types for the deserializer
 * configuration register bank.
 * Assumes a single 25 MHz system clock and a two-wire serial control bus
 * whose lines reach the bank through ordinary pins.
 */
package deser_cfg_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_MAIN_CONFIG = 8'h00;
	localparam logic [7:0] REG_BUS_ADDR = 8'h01;
	localparam logic [7:0] REG_OUT_FEATURES = 8'h02;
	localparam logic [7:0] MAIN_CONFIG_RESET = 8'h00;
	localparam logic [7:0] BUS_ADDR_RESET = 8'h70;
	localparam logic [7:0] OUT_FEATURES_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
	localparam logic [2:0] BIT_COUNT_LAST = 3'h7;

	// ------------------------------------------------------------
	// Field layouts and modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_NORMAL_NOFILTER = 2'h0,
		MODE_NORMAL_FILTER = 2'h1,
		MODE_LEGACY_GEN2 = 2'h2,
		MODE_LEGACY_GEN1 = 2'h3
	} compat_mode_t;

	typedef struct packed {
		logic low_freq_spread_range;
		logic lane_bit_order_select;
		logic [1:0] reserved_bits;
		compat_mode_t compat_mode_field;
		logic sleep;
		logic config_source_select;
	} main_cfg_t;

	typedef struct packed {
		logic bus_address_source;
		logic [6:0] bus_address_field;
	} bus_addr_t;

	typedef struct packed {
		logic output_enable_bit;
		logic output_idle_state_select;
		logic [1:0] reserved_bits;
		logic swing_select;
		logic [2:0] fallback_oscillator_select;
	} out_feat_t;

	// Strap and control pins
	typedef struct packed {
		compat_mode_t compat_mode;
		logic lane_bit_order;
		logic low_freq_range;
		logic output_enable;
		logic output_idle_state;
		logic swing;
		logic [6:0] pin_address;
	} strap_pins_t;

	// Effective configuration handed to the deserializer core
	typedef struct packed {
		logic low_freq_spread_range;
		logic lane_bit_order_select;
		compat_mode_t compat_mode;
		logic sleep;
		logic output_enable_bit;
		logic output_idle_state_select;
		logic swing_select;
		logic [2:0] fallback_oscillator_select;
		logic [6:0] active_address;
	} core_cfg_t;

	typedef enum {BUS_IDLE, BUS_RX, BUS_ACK, BUS_TX, BUS_MACK} bus_state_t;
	typedef enum {KIND_ADDR, KIND_PTR, KIND_DATA} byte_kind_t;

endpackage

//--- tb/serial_host_model.sv
/*
 * Host controller model for the two-wire serial control bus.
 * Assumes a pulled-up SDA wire resolved by the bench and the 25 MHz clock.
 */
`timescale 1ns/1ns
module serial_host_model (
	// Clock
	input wire logic clk_sys_in,
	// Bus wires
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_oe_out
);
	// ----------------------------------------
	// Bus timing
	// ----------------------------------------
	// Idle bus: clock stands high, data released, outside frames
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	// SCL levels of six clocks or more, above the slave's minimum of four
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	// Data moves a few clocks after SCL falls, never in the same step
	task automatic start();
		wait_clk(3);
		sda_oe_out = 1'b0;
		wait_clk(6);
		scl_out = 1'b1;
		wait_clk(6);
		sda_oe_out = 1'b1;
		wait_clk(6);
		scl_out = 1'b0;
	endtask
	task automatic stop();
		wait_clk(3);
		sda_oe_out = 1'b1;
		wait_clk(6);
		scl_out = 1'b1;
		wait_clk(6);
		sda_oe_out = 1'b0;
		wait_clk(6);
	endtask
	task automatic clock_bit(input logic b, output logic seen);
		wait_clk(3);
		sda_oe_out = ~b;
		wait_clk(6);
		scl_out = 1'b1;
		wait_clk(6);
		seen = sda_in;
		scl_out = 1'b0;
	endtask
	// ----------------------------------------
	// Byte and register transfers
	// ----------------------------------------
	// Reading sends all ones so the wire is free; last is 1 to release the ack slot
	task automatic xfer_byte(input logic [7:0] tx, input logic last, output logic [7:0] rx,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(tx[i], s);
			rx[i] = s;
		end
		clock_bit(last, s);
		ack = ~s;
	endtask
	task automatic wr(input logic [6:0] addr, input logic [7:0] ptr, input logic [7:0] data,
		output logic ok);
		logic [7:0] rx;
		logic a0, a1, a2;
		start();
		xfer_byte({addr, 1'b0}, 1'b1, rx, a0);
		xfer_byte(ptr, 1'b1, rx, a1);
		xfer_byte(data, 1'b1, rx, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask
	// Pointer write, repeated start, one byte read with a closing nack
	task automatic rd(input logic [6:0] addr, input logic [7:0] ptr, output logic [7:0] data,
		output logic ok);
		logic [7:0] rx;
		logic a0, a1, a2, a3;
		start();
		xfer_byte({addr, 1'b0}, 1'b1, rx, a0);
		xfer_byte(ptr, 1'b1, rx, a1);
		start();
		xfer_byte({addr, 1'b1}, 1'b1, rx, a2);
		xfer_byte(8'hff, 1'b1, data, a3);
		stop();
		ok = a0 & a1 & a2;
	endtask
endmodule // serial_host_model

//--- tb/testbench.sv
/*
 * Self-checking bench for the deserializer configuration register bank.
 * Assumes the host model in tb/serial_host_model.sv and the design package.
 */
`timescale 1ns/1ns
module testbench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int LIMIT = 80000;
	typedef struct packed {
		logic [7:0] ptr;
		logic [7:0] data;
		logic [7:0] rdback;
	} row_t;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic sda_out, sda_oe_out, host_scl, host_oe, ok;
	logic [7:0] rd_data, junk;
	logic [7:0] shadow [3];
	logic [6:0] addr;
	wire logic sda;
	deser_cfg_pkg::strap_pins_t pins = 14'h2ef2;
	deser_cfg_pkg::core_cfg_t core_cfg_out;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	// Reserved bits are always written as zero by the host
	row_t rows [13] = '{
		24'h00_81_81,
		24'h00_41_41,
		24'h00_01_01,
		24'h00_05_05,
		24'h00_09_09,
		24'h00_0d_0d,
		24'h00_03_03,
		24'h02_c0_c0,
		24'h02_08_08,
		24'h02_07_07,
		24'h00_0e_0e,
		24'h01_f1_f1,
		24'h01_76_76
	};
	// 25 MHz clock; pulled-up SDA, low whenever a party pulls it
	always #20 clk_sys_in = ~clk_sys_in;
	assign sda = host_oe ? 1'b0 : (sda_oe_out ? sda_out : 1'b1);
	serial_host_model host (
		.clk_sys_in(clk_sys_in),
		.sda_in(sda),
		.scl_out(host_scl),
		.sda_oe_out(host_oe)
	);
	deser_config_register_bank uut (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.scl_in(host_scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe_out(sda_oe_out),
		.strap_pins_in(pins),
		.core_cfg_out(core_cfg_out)
	);
	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Configuration the core should see, from the shadow registers and straps
	function automatic deser_cfg_pkg::core_cfg_t expect_cfg();
		deser_cfg_pkg::core_cfg_t e;
		logic src;
		src = shadow[0][0];
		e.low_freq_spread_range = src ? shadow[0][7] : pins.low_freq_range;
		e.lane_bit_order_select = src ? shadow[0][6] : pins.lane_bit_order;
		e.compat_mode = deser_cfg_pkg::compat_mode_t'(src ? shadow[0][3:2] : pins.compat_mode);
		e.sleep = shadow[0][1];
		e.output_enable_bit = src ? shadow[2][7] : pins.output_enable;
		e.output_idle_state_select = src ? shadow[2][6] : pins.output_idle_state;
		e.swing_select = src ? shadow[2][3] : pins.swing;
		e.fallback_oscillator_select = shadow[2][2:0];
		e.active_address = shadow[1][7] ? shadow[1][6:0] : pins.pin_address;
		return e;
	endfunction
	// Reads every register back, then compares the core configuration
	task automatic check_regs();
		for (int r = 0; r < 3; r++) begin
			host.rd(addr, 8'(r), rd_data, ok);
			chk("read ack", 32'h1, {31'h0, ok});
			chk("read data", {24'h0, shadow[r]}, {24'h0, rd_data});
		end
		chk("core cfg", {14'h0, expect_cfg()}, {14'h0, core_cfg_out});
	endtask
	// Reset held for ten cycles; the bus stays quiet three edges after release
	task automatic do_reset();
		rst_n_in = 1'b0;
		repeat (10) @(posedge clk_sys_in);
		#1;
		chk("oe in reset", 32'h0, {31'h0, sda_oe_out});
		chk("cfg in reset", 32'h0, {14'h0, core_cfg_out});
		chk("sda value", 32'h0, {31'h0, sda_out});
		rst_n_in = 1'b1;
		repeat (3) @(posedge clk_sys_in);
		#1;
		shadow = '{8'h00, 8'h70, 8'h00};
		addr = pins.pin_address;
	endtask
	task automatic summarize();
		if (fails == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	// Hang guard: a bound well above the expected run length
	always @(posedge clk_sys_in) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fails++;
			summarize();
		end
	end
	initial begin
		do_reset();
		check_regs();
		foreach (rows[i]) begin
			host.wr(addr, rows[i].ptr, rows[i].data, ok);
			chk("write ack", 32'h1, {31'h0, ok});
			shadow[rows[i].ptr[1:0]] = rows[i].rdback;
			if (rows[i].ptr == 8'h01) begin
				addr = rows[i].data[7] ? rows[i].data[6:0] : pins.pin_address;
			end
			check_regs();
		end
		// Unmapped pointer: acked, discarded, reads as zero
		host.wr(addr, 8'h03, 8'h5a, ok);
		chk("unmapped ack", 32'h1, {31'h0, ok});
		host.rd(addr, 8'h03, rd_data, ok);
		chk("unmapped read", 32'h0, {24'h0, rd_data});
		// Another address is ignored and changes nothing
		host.wr(addr ^ 7'h01, 8'h00, 8'hff, ok);
		chk("foreign ack", 32'h0, {31'h0, ok});
		check_regs();
		// One frame fills three registers through pointer auto-increment
		host.start();
		host.xfer_byte({addr, 1'b0}, 1'b1, junk, ok);
		chk("frame addr ack", 32'h1, {31'h0, ok});
		host.xfer_byte(8'h00, 1'b1, junk, ok);
		chk("frame ptr ack", 32'h1, {31'h0, ok});
		host.xfer_byte(8'h01, 1'b1, junk, ok);
		chk("frame data ack", 32'h1, {31'h0, ok});
		host.xfer_byte(8'h72, 1'b1, junk, ok);
		chk("frame data ack", 32'h1, {31'h0, ok});
		host.xfer_byte(8'h40, 1'b1, junk, ok);
		chk("frame data ack", 32'h1, {31'h0, ok});
		host.stop();
		shadow = '{8'h01, 8'h72, 8'h40};
		check_regs();
		// Fresh strap levels, same pin address, reach the core once pins rule again
		pins = 14'h1172;
		host.wr(addr, 8'h00, 8'h00, ok);
		chk("pin mode ack", 32'h1, {31'h0, ok});
		shadow[0] = 8'h00;
		check_regs();
		// Second reset in mid-run restores the defaults
		do_reset();
		check_regs();
		summarize();
	end
endmodule // testbench
